// file: bench/pm_host_model.sv
// Host software model making byte accesses in system I/O space
`timescale 1ns/100ps
module pm_host_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] ioRdData,
	input  wire logic       ioRdValid,
	output logic            ioSel,
	output logic            ioRd,
	output logic            ioWr,
	output logic      [3:0] ioAddr,
	output logic      [7:0] ioWrData
);
	// Bus idle from time zero
	initial begin
		ioSel = 1'b0;
		ioRd = 1'b0;
		ioWr = 1'b0;
		ioAddr = 4'h0;
		ioWrData = 8'h00;
	end

	// One access held over one edge; read data taken while valid stands.
	// An idle edge follows, so back-to-back calls always drop each strobe between accesses
	task automatic xfer(input logic r, input logic [3:0] a,
		input logic [7:0] w, output logic [7:0] d);
		ioSel = 1'b1;
		ioRd = r;
		ioWr = !r;
		ioAddr = a;
		ioWrData = w;
		@(posedge core_clk);
		#1;
		d = (ioRdValid === 1'b1) ? ioRdData : 8'hxx;
		ioSel = 1'b0;
		ioRd = 1'b0;
		ioWr = 1'b0;
		ioAddr = ~a;
		ioWrData = ~w;
		@(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] w);
		logic [7:0] discard;
		xfer(1'b0, a, w, discard);
	endtask

	// Single byte read; no valid pulse gives unknown data
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		xfer(1'b1, a, 8'h00, d);
	endtask
endmodule

// file: bench/pm_timer_event_control_assertions.sv
// Port-level checker for the PM timer and event control block
`timescale 1ns/100ps
module pm_timer_event_control_assertions (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        ioSel,
	input wire logic        ioRd,
	input wire logic        ioWr,
	input wire logic [3:0]  ioAddr,
	input wire logic [7:0]  ioWrData,
	input wire logic [7:0]  ioRdData,
	input wire logic        inputClockRun,
	input wire logic        workingState,
	input wire logic        timerRunControl,
	input wire logic        timerCarryFlagClear,
	input wire logic        timerCarryFlag,
	input wire logic        firmwareStatusClear,
	input wire logic        firmwareStatus,
	input wire logic        firmwareEventEnable,
	input wire logic        busMasterControl,
	input wire logic [23:0] timerCountValue,
	input wire logic        sciReq,
	input wire logic        smiReq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// Helper terms; tick lag means run must be low for a few cycles
	logic       runOk;
	logic       wrCtl;
	logic [7:0] cntLow;
	logic       cntTop;
	assign runOk = inputClockRun && timerRunControl && workingState;
	assign wrCtl = ioSel && ioWr && (ioAddr == 4'h4);
	assign cntLow = timerCountValue[7:0];
	assign cntTop = timerCountValue[23];

	rsvd_read_zero_a: assert property (
		ioSel && ioRd && ioAddr inside {4'h3, 4'h5, 4'h6, 4'h7}
		|=> ioRdData == 8'h00) else $error("reserved read not zero");
	count_byte_read_a: assert property (
		ioSel && ioRd && ioAddr == 4'h8 |=> ioRdData == $past(cntLow))
		else $error("count byte read wrong");
	count_hold_a: assert property (
		!runOk [*3] |=> $stable(timerCountValue))
		else $error("count moved while held");
	// A mid-run reset drops the count to zero; skip the edge after it
	count_step_a: assert property (
		$changed(timerCountValue) && $past(rst_n)
		|-> timerCountValue == $past(timerCountValue) + 24'h1)
		else $error("count step not one");
	carry_set_a: assert property (
		$changed(cntTop) && $past(rst_n) |-> timerCarryFlag)
		else $error("carry flag not set");
	carry_sticky_a: assert property (
		timerCarryFlag && !timerCarryFlagClear |=> timerCarryFlag)
		else $error("carry flag lost");
	release_status_a: assert property (
		wrCtl && ioWrData[2] |=> firmwareStatus)
		else $error("firmware status not set");
	release_smi_a: assert property (
		wrCtl && ioWrData[2] && firmwareEventEnable ##1 firmwareEventEnable
		|=> smiReq) else $error("release smi missing");
	reload_sci_a: assert property (
		wrCtl && ioWrData[1] && busMasterControl ##1 busMasterControl
		|=> sciReq) else $error("reload sci missing");
	status_clear_a: assert property (
		firmwareStatusClear && !(wrCtl && ioWrData[2]) |=> !firmwareStatus)
		else $error("firmware status not cleared");
endmodule

bind pm_timer_event_control pm_timer_event_control_assertions
	pm_timer_event_control_assertions_inst (.core_clk, .rst_n, .ioSel,
	.ioRd, .ioWr, .ioAddr, .ioWrData, .ioRdData, .inputClockRun,
	.workingState, .timerRunControl, .timerCarryFlagClear,
	.timerCarryFlag, .firmwareStatusClear, .firmwareStatus,
	.firmwareEventEnable, .busMasterControl, .timerCountValue, .sciReq,
	.smiReq);

// file: bench/pm_timer_event_control_test.sv
// Self-checking bench for the PM timer and event control block
`timescale 1ns/100ps
module pm_timer_event_control_test;
	logic        core_clk, rst_n, ioSel, ioRd, ioWr, ioRdValid;
	logic        inputClockRun, workingState, timerRunControl;
	logic        timerCarryIrqEnable, timerCarryFlagClear, timerCarryFlag;
	logic        firmwareStatusClear, firmwareStatus, firmwareEventEnable;
	logic        mgmtIrqEnable, busMasterControl, sciReq, smiReq;
	logic [3:0]  ioAddr;
	logic [7:0]  ioWrData, ioRdData, d;
	logic [23:0] v, timerCountValue;
	int          errorCnt, checksDone;

	pm_timer_event_control pm_timer_event_control_inst (.core_clk, .rst_n,
		.ioSel, .ioRd, .ioWr, .ioAddr, .ioWrData, .ioRdData, .ioRdValid,
		.inputClockRun, .workingState, .timerRunControl,
		.timerCarryIrqEnable, .timerCarryFlagClear, .timerCarryFlag,
		.firmwareStatusClear, .firmwareStatus, .firmwareEventEnable,
		.mgmtIrqEnable, .busMasterControl, .timerCountValue, .sciReq,
		.smiReq);
	pm_host_model pm_host_model_inst (.core_clk, .ioRdData, .ioRdValid,
		.ioSel, .ioRd, .ioWr, .ioAddr, .ioWrData);

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task stopTest;
		if (errorCnt == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input logic [23:0] got, input logic [23:0] exp);
		checksDone++;
		if (got !== exp) begin
			errorCnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Every write must vanish except the three live control bits
	task tRegs;
		for (int a = 3; a <= 10; a++)
			pm_host_model_inst.wr(4'(a), (a == 4) ? 8'hf8 : 8'hff);
		for (int a = 3; a <= 10; a++) begin
			pm_host_model_inst.rd(4'(a), d);
			chk(24'(d), 24'h0);
		end
		chk(24'(firmwareStatus), 24'h0);
	endtask

	// Release with and without the firmware event enable
	task tRelease;
		firmwareEventEnable = 1'b1;
		pm_host_model_inst.wr(4'h4, 8'h04);
		chk(24'(firmwareStatus), 24'h1);
		step(1);
		chk(24'(smiReq), 24'h1);
		pm_host_model_inst.wr(4'h4, 8'h00);
		pm_host_model_inst.rd(4'h4, d);
		chk(24'(d), 24'h4);
		firmwareStatusClear = 1'b1;
		step(1);
		firmwareStatusClear = 1'b0;
		chk(24'(firmwareStatus), 24'h0);
		step(1);
		chk(24'(smiReq), 24'h0);
		pm_host_model_inst.rd(4'h4, d);
		chk(24'(d), 24'h0);
		firmwareEventEnable = 1'b0;
		pm_host_model_inst.wr(4'h4, 8'h04);
		step(1);
		chk(24'(smiReq), 24'h0);
		firmwareStatusClear = 1'b1;
		step(1);
		firmwareStatusClear = 1'b0;
	endtask

	// Reload needs both the control bit and the enable
	task tBusMaster;
		busMasterControl = 1'b1;
		mgmtIrqEnable = 1'b1;
		step(2);
		chk(24'(sciReq), 24'h0);
		pm_host_model_inst.wr(4'h4, 8'h02);
		step(1);
		chk(24'(sciReq), 24'h1);
		busMasterControl = 1'b0;
		step(2);
		chk(24'(sciReq), 24'h0);
	endtask

	// Each of the three run conditions stops and holds the count
	task tTimer;
		for (int i = 1; i <= 3; i++) begin
			{inputClockRun, workingState, timerRunControl} = 3'b111;
			step(280);
			{inputClockRun, workingState, timerRunControl} =
				3'b111 ^ 3'(4 >> (i - 1));
			step(3);
			v = timerCountValue;
			step(100);
			chk(timerCountValue, v);
			chk(24'(v >= 10 * i - 1 && v <= 10 * i + 1), 24'h1);
		end
		for (int b = 0; b < 3; b++) begin
			pm_host_model_inst.wr(4'(8 + b), 8'hff);
			pm_host_model_inst.rd(4'(8 + b), d);
			chk(24'(d), 24'(v[8 * b +: 8]));
		end
		timerCarryFlagClear = 1'b1;
		step(1);
		timerCarryFlagClear = 1'b0;
		chk(24'(timerCarryFlag), 24'h0);
	endtask

	// Reset in mid-run clears count and control
	task tReset;
		timerRunControl = 1'b1;
		pm_host_model_inst.wr(4'h4, 8'h02);
		step(50);
		rst_n = 1'b0;
		step(1);
		rst_n = 1'b1;
		chk(timerCountValue, 24'h0);
		// First access only in the cycle after the first edge out of reset
		step(1);
		pm_host_model_inst.rd(4'h4, d);
		chk(24'(d), 24'h0);
	endtask

	// Main sequence
	initial begin
		errorCnt = 0;
		checksDone = 0;
		rst_n = 1'b0;
		{inputClockRun, workingState, timerRunControl} = 3'b000;
		{timerCarryIrqEnable, timerCarryFlagClear} = 2'b10;
		{firmwareStatusClear, firmwareEventEnable} = 2'b00;
		{mgmtIrqEnable, busMasterControl} = 2'b00;
		step(3);
		rst_n = 1'b1;
		step(1);
		tRegs;
		tRelease;
		tBusMaster;
		tTimer;
		tReset;
		stopTest;
	end

	// Run needs about 1300 cycles
	initial begin
		#40000;
		errorCnt++;
		stopTest;
	end
endmodule

// file: hdl/pm_event_if.sv
// Event sources passed from the register core to the interrupt router
`timescale 1ns/100ps
interface pm_event_if;
	logic timerEvent;
	logic eventRouteSelect;
	logic mgmtIrqEnable;
	logic busMasterReload;
	logic globalRelease;
	logic firmwareEventEnable;
	logic sciReq;
	logic smiReq;

	modport core (
		output timerEvent,
		output eventRouteSelect,
		output mgmtIrqEnable,
		output busMasterReload,
		output globalRelease,
		output firmwareEventEnable,
		input  sciReq,
		input  smiReq
	);

	modport router (
		input  timerEvent,
		input  eventRouteSelect,
		input  mgmtIrqEnable,
		input  busMasterReload,
		input  globalRelease,
		input  firmwareEventEnable,
		output sciReq,
		output smiReq
	);
endinterface

// file: hdl/pm_event_router.sv
// Routes power events onto the SCI and SMI request outputs
`timescale 1ns/100ps
module pm_event_router (
	input  wire logic core_clk,
	input  wire logic rst_n,
	pm_event_if.router ev
);
	logic sciNxt;
	logic smiNxt;

	// Combine sources; timer event follows the route select
	always_comb begin
		sciNxt = 1'b0;
		smiNxt = 1'b0;
		if (ev.timerEvent && ev.eventRouteSelect)
			sciNxt = 1'b1;
		if (ev.timerEvent && !ev.eventRouteSelect && ev.mgmtIrqEnable)
			smiNxt = 1'b1;
		if (ev.busMasterReload)
			sciNxt = 1'b1;
		if (ev.globalRelease && ev.firmwareEventEnable)
			smiNxt = 1'b1;
	end

	// Registered so the request pins never glitch
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ev.sciReq <= 1'b0;
			ev.smiReq <= 1'b0;
		end else begin
			ev.sciReq <= sciNxt;
			ev.smiReq <= smiNxt;
		end
	end
endmodule

// file: hdl/pm_tick_divider.sv
// Fractional divider giving one-cycle timer tick enables from core_clk
`include "pm_timer_consts.svh"
`timescale 1ns/100ps
module pm_tick_divider (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      tick
);
	localparam logic [`PM_ACC_WIDTH-1:0] STEP =
		`PM_ACC_WIDTH'(`PM_TICK_RATE_HZ);
	localparam logic [`PM_ACC_WIDTH-1:0] MODULUS =
		`PM_ACC_WIDTH'(`PM_CORE_RATE_HZ);

	logic [`PM_ACC_WIDTH-1:0] phase_r;
	logic [`PM_ACC_WIDTH-1:0] phaseSum;

	// Average tick rate is exact; single ticks jitter by one core cycle
	assign phaseSum = phase_r + STEP;

	// Phase holds while stopped, so a restart resumes the fraction
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase_r <= '0;
			tick    <= 1'b0;
		end else if (run) begin
			if (phaseSum >= MODULUS) begin
				phase_r <= phaseSum - MODULUS;
				tick    <= 1'b1;
			end else begin
				phase_r <= phaseSum;
				tick    <= 1'b0;
			end
		end else begin
			tick <= 1'b0;
		end
	end
endmodule

// file: hdl/pm_timer_consts.svh
// Offsets, field positions, reset values and timing figures of the PM block
`ifndef PM_TIMER_CONSTS_SVH
`define PM_TIMER_CONSTS_SVH

// Byte offsets from the block base in system I/O space
`define PM_OFS_ENABLE_UPPER 4'h3
`define PM_OFS_CONTROL_LOW  4'h4
`define PM_OFS_CONTROL_2ND  4'h5
`define PM_OFS_CONTROL_3RD  4'h6
`define PM_OFS_CONTROL_4TH  4'h7
`define PM_OFS_COUNT_BYTE0  4'h8
`define PM_OFS_COUNT_BYTE1  4'h9
`define PM_OFS_COUNT_BYTE2  4'ha

// Field positions in the low control register
`define PM_CTL_ROUTE_BIT    0
`define PM_CTL_BMRLD_BIT    1
`define PM_CTL_GREL_BIT     2

// Reset values
`define PM_CONTROL_RESET    8'h00
`define PM_RSVD_READ        8'h00
`define PM_COUNT_RESET      24'h000000
`define PM_COUNT_MSB        23

// Timer rate in Hz and core rate in Hz; tick spacing is their ratio
`define PM_TICK_RATE_HZ     3579545
`define PM_CORE_RATE_HZ     100000000
`define PM_ACC_WIDTH        27

`endif

// file: hdl/pm_timer_event_control.sv
// PM timer, carry flag, control register and event routing top level
`include "pm_timer_consts.svh"
`timescale 1ns/100ps
module pm_timer_event_control (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       ioSel,
	input  wire logic       ioRd,
	input  wire logic       ioWr,
	input  wire logic [3:0] ioAddr,
	input  wire logic [7:0] ioWrData,
	output logic      [7:0] ioRdData,
	output logic            ioRdValid,
	input  wire logic       inputClockRun,
	input  wire logic       workingState,
	input  wire logic       timerRunControl,
	input  wire logic       timerCarryIrqEnable,
	input  wire logic       timerCarryFlagClear,
	output logic            timerCarryFlag,
	input  wire logic       firmwareStatusClear,
	output logic            firmwareStatus,
	input  wire logic       firmwareEventEnable,
	input  wire logic       mgmtIrqEnable,
	input  wire logic       busMasterControl,
	output logic [23:0]     timerCountValue,
	output logic            sciReq,
	output logic            smiReq
);

	pm_timer_pkg::pm_ctrl_t      ctrl_r;
	pm_timer_pkg::pm_ctrl_t      ctrl_nxt;
	pm_timer_pkg::pm_run_state_t runState;
	pm_timer_pkg::pm_reg_sel_t   wrSel;
	pm_timer_pkg::pm_reg_sel_t   rdSel;
	logic [23:0]                 count_r;
	logic [23:0]                 countInc;
	logic                        tick;
	logic                        runEnable;
	logic                        wrStrobe;
	logic                        rdStrobe;
	logic                        carrySet;
	logic                        carryFlag_r;
	logic                        fwStatus_r;
	logic                        releaseSet;
	logic [7:0]                  rdMux;

	pm_event_if evBus ();

	// Map a block-relative offset to the register it selects
	function automatic pm_timer_pkg::pm_reg_sel_t decodeOffset(
		input logic [3:0] ofs
	);
		pm_timer_pkg::pm_reg_sel_t sel;
		sel = pm_timer_pkg::SEL_NONE;
		case (ofs)
			`PM_OFS_ENABLE_UPPER: sel = pm_timer_pkg::SEL_RESERVED;
			`PM_OFS_CONTROL_LOW:  sel = pm_timer_pkg::SEL_CONTROL_LOW;
			`PM_OFS_CONTROL_2ND:  sel = pm_timer_pkg::SEL_RESERVED;
			`PM_OFS_CONTROL_3RD:  sel = pm_timer_pkg::SEL_RESERVED;
			`PM_OFS_CONTROL_4TH:  sel = pm_timer_pkg::SEL_RESERVED;
			`PM_OFS_COUNT_BYTE0:  sel = pm_timer_pkg::SEL_COUNT_BYTE0;
			`PM_OFS_COUNT_BYTE1:  sel = pm_timer_pkg::SEL_COUNT_BYTE1;
			`PM_OFS_COUNT_BYTE2:  sel = pm_timer_pkg::SEL_COUNT_BYTE2;
			default:              sel = pm_timer_pkg::SEL_NONE;
		endcase
		return sel;
	endfunction

	// Pick one byte of the live count
	function automatic logic [7:0] countByte(
		input logic [23:0] value,
		input logic [1:0]  idx
	);
		logic [7:0] b;
		b = `PM_RSVD_READ;
		case (idx)
			2'h0:    b = value[7:0];
			2'h1:    b = value[15:8];
			2'h2:    b = value[23:16];
			default: b = `PM_RSVD_READ;
		endcase
		return b;
	endfunction

	// Access strobes and register selects
	assign wrStrobe = ioSel && ioWr;
	assign rdStrobe = ioSel && ioRd;
	assign wrSel    = decodeOffset(ioAddr);
	assign rdSel    = decodeOffset(ioAddr);

	// Timer advance path: stopped clock, timer off or sleep all hold it
	assign runState = (inputClockRun && timerRunControl && workingState)
		? pm_timer_pkg::RUN_COUNTING : pm_timer_pkg::RUN_HELD;
	always_comb begin
		case (runState)
			pm_timer_pkg::RUN_COUNTING: runEnable = 1'b1;
			pm_timer_pkg::RUN_HELD:     runEnable = 1'b0;
			default:                    runEnable = 1'b0;
		endcase
	end

	// Tick enables at the timer rate, derived from core_clk
	pm_tick_divider pm_tick_divider_inst (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run      (runEnable),
		.tick     (tick)
	);

	assign countInc = count_r + 24'h000001;

	// Count only moves on a tick; held value survives a clock stop
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			count_r <= `PM_COUNT_RESET;
		else if (tick)
			count_r <= countInc;
	end

	// Bit 23 toggles on the tick that moves it, in either direction
	assign carrySet = tick &&
		(countInc[`PM_COUNT_MSB] != count_r[`PM_COUNT_MSB]);

	// Hardware set beats a same-cycle software clear
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			carryFlag_r <= 1'b0;
		else if (carrySet)
			carryFlag_r <= 1'b1;
		else if (timerCarryFlagClear)
			carryFlag_r <= 1'b0;
	end

	// A write of one to the global release bit is the release event
	assign releaseSet = wrStrobe &&
		(wrSel == pm_timer_pkg::SEL_CONTROL_LOW) &&
		ioWrData[`PM_CTL_GREL_BIT];

	// Control register next value; writes of zero to release do nothing
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wrStrobe && (wrSel == pm_timer_pkg::SEL_CONTROL_LOW)) begin
			ctrl_nxt.eventRouteSelect      = ioWrData[`PM_CTL_ROUTE_BIT];
			ctrl_nxt.busMasterReloadEnable = ioWrData[`PM_CTL_BMRLD_BIT];
		end
		if (firmwareStatusClear)
			ctrl_nxt.globalRelease = 1'b0;
		if (releaseSet)
			ctrl_nxt.globalRelease = 1'b1;
		ctrl_nxt.reserved = '0;
	end

	// Reserved registers have no storage, so writes to them vanish
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			ctrl_r <= `PM_CONTROL_RESET;
		else
			ctrl_r <= ctrl_nxt;
	end

	// Firmware status follows a release; a new release beats the clear
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			fwStatus_r <= 1'b0;
		else if (releaseSet)
			fwStatus_r <= 1'b1;
		else if (firmwareStatusClear)
			fwStatus_r <= 1'b0;
	end

	// Read data multiplexer; unmapped offsets read zero as well
	always_comb begin
		rdMux = `PM_RSVD_READ;
		case (rdSel)
			pm_timer_pkg::SEL_CONTROL_LOW: rdMux = ctrl_r;
			pm_timer_pkg::SEL_RESERVED:    rdMux = `PM_RSVD_READ;
			pm_timer_pkg::SEL_COUNT_BYTE0: rdMux = countByte(count_r, 2'h0);
			pm_timer_pkg::SEL_COUNT_BYTE1: rdMux = countByte(count_r, 2'h1);
			pm_timer_pkg::SEL_COUNT_BYTE2: rdMux = countByte(count_r, 2'h2);
			pm_timer_pkg::SEL_NONE:        rdMux = `PM_RSVD_READ;
			default:                       rdMux = `PM_RSVD_READ;
		endcase
	end

	// Each byte is sampled live at its own read, no upper-byte latch
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ioRdData  <= `PM_RSVD_READ;
			ioRdValid <= 1'b0;
		end else begin
			ioRdValid <= rdStrobe;
			if (rdStrobe)
				ioRdData <= rdMux;
		end
	end

	// Event sources handed to the router
	assign evBus.timerEvent =
		carryFlag_r && timerCarryIrqEnable;
	assign evBus.eventRouteSelect    = ctrl_r.eventRouteSelect;
	assign evBus.mgmtIrqEnable       = mgmtIrqEnable;
	assign evBus.busMasterReload     =
		ctrl_r.busMasterReloadEnable && busMasterControl;
	assign evBus.globalRelease       = ctrl_r.globalRelease;
	assign evBus.firmwareEventEnable = firmwareEventEnable;

	pm_event_router pm_event_router_inst (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ev       (evBus)
	);

	// Visible state; all from flip-flops
	assign timerCarryFlag  = carryFlag_r;
	assign firmwareStatus  = fwStatus_r;
	assign timerCountValue = count_r;
	assign sciReq          = evBus.sciReq;
	assign smiReq          = evBus.smiReq;

endmodule

// file: hdl/pm_timer_pkg.sv
// Types shared by the PM timer and event control block
package pm_timer_pkg;

	// Layout of the low control register
	typedef struct packed {
		logic [4:0] reserved;
		logic       globalRelease;
		logic       busMasterReloadEnable;
		logic       eventRouteSelect;
	} pm_ctrl_t;

	// Register selected by a block-relative offset
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_RESERVED,
		SEL_CONTROL_LOW,
		SEL_COUNT_BYTE0,
		SEL_COUNT_BYTE1,
		SEL_COUNT_BYTE2
	} pm_reg_sel_t;

	// Condition of the count advance path
	typedef enum logic [1:0] {
		RUN_HELD,
		RUN_COUNTING
	} pm_run_state_t;

endpackage
